// ===== hw/wser_top.sv
// Latched warning flags and forward energy readout of the power monitor
`timescale 1ns/100ps
`default_nettype none
`include "wser_cfg.svh"

// How it works
// [RULE_01] Overcurrent flag, current status bit 5, latches when current passes threshold.
// [RULE_02] Current status bits 7:6 always read zero.
// [RULE_03] Primary overvoltage flag, input status bit 6, latches above threshold.
// [RULE_04] Primary undervoltage flag, input status bit 5, latches below threshold.
// [RULE_05] Overpower flag, input status bit 0, latches when power passes threshold.
// [RULE_06] Input status bits 7 and 4:1 always read zero.
// [RULE_07] Aux overvoltage flag, vendor status bit 6, latches above threshold.
// [RULE_08] Aux undervoltage flag, vendor status bit 5, latches below threshold.
// [RULE_09] Current status 4:0, vendor status 4:0 and 7 read zero.
// [RULE_10] Energy readout fields are captured together as one snapshot.
// [RULE_11] Forward accumulator only adds power when current is positive.
// [RULE_12] Bits 47:24 count samples added to either accumulator.
// [RULE_13] Sample tally byte 5 high, byte 4 middle, byte 3 low.
// [RULE_14] Unsigned variant: wrap counter steps when count wraps FFFF to 0.
// [RULE_15] Signed variant: wrap counter steps when count wraps 7FFF to 0.
// [RULE_16] Wrap counter is unsigned eight bits in bits 23:16.
// [RULE_17] Accumulator is 24 bits; top 16 bits returned in 15:0.
// [RULE_18] Energy count unsigned in one variant, twos complement in other.
// [RULE_19] Energy count high byte in byte 1, low byte in byte 0.
// [RULE_20] Summary bits go high while any flag of their status byte is set.
// [RULE_21] A threshold left at its reset value disables its flag.
// [RULE_22] Flags stay set until host clear command or reset.
// [RULE_23] Tally steps once per sample added to either accumulator.
module wser_top #(
    parameter bit SIGNED_VARIANT = 1'b0
) (
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_reset,
    // Averaged measurements, one-cycle sample strobe
    input  wire logic                i_sample_valid,
    input  wire logic signed [15:0]  i_sensed_current,
    input  wire logic [11:0]         i_primary_input_voltage,
    input  wire logic [11:0]         i_auxiliary_input_voltage,
    input  wire logic signed [15:0]  i_input_power,
    // Warning thresholds
    input  wire logic signed [15:0]  i_overcurrent_threshold,
    input  wire logic [11:0]         i_primary_overvoltage_threshold,
    input  wire logic [11:0]         i_primary_undervoltage_threshold,
    input  wire logic signed [15:0]  i_overpower_threshold,
    input  wire logic [11:0]         i_aux_overvoltage_threshold,
    input  wire logic [11:0]         i_aux_undervoltage_threshold,
    // Command port: read strobe with command code, flag clear strobe
    input  wire logic                i_rd_strobe,
    input  wire logic [7:0]          i_rd_command,
    input  wire logic                i_clear_faults,
    // Read answer
    output logic                     o_rd_valid,
    output logic                     o_rd_hit,
    output wser_pkg::wser_energy_t   o_rd_data,
    // Live summary bits of the status word
    output logic                     o_current_summary_bit,
    output logic                     o_input_summary_bit,
    output logic                     o_vendor_summary_bit
);
    import wser_pkg::*;

    logic [7:0]   cur_status_reg, cur_status_next;
    logic [7:0]   in_status_reg, in_status_next;
    logic [7:0]   vnd_status_reg, vnd_status_next;
    logic [23:0]  acc_reg, acc_next;
    logic [7:0]   wrap_reg, wrap_next;
    logic [23:0]  tally_reg, tally_next;
    logic         rd_valid_reg, rd_valid_next;
    logic         rd_hit_reg, rd_hit_next;
    wser_energy_t rd_data_reg, rd_data_next;
    logic [2:0]   summary_reg, summary_next;
    wser_rd_state_t rd_state_reg, rd_state_next;

    logic         oc_hit, pov_hit, puv_hit, op_hit, aov_hit, auv_hit;
    logic [24:0]  acc_sum;
    logic [23:0]  acc_top;
    logic         acc_wrap;

    // [RULE_21] disabled thresholds
    always_comb begin
        oc_hit  = (i_overcurrent_threshold != `WSER_OC_DISABLE)
                  && (i_sensed_current > i_overcurrent_threshold);
        pov_hit = (i_primary_overvoltage_threshold != `WSER_VOV_DISABLE)
                  && (i_primary_input_voltage
                      > i_primary_overvoltage_threshold);
        puv_hit = (i_primary_undervoltage_threshold != `WSER_VUV_DISABLE)
                  && (i_primary_input_voltage
                      < i_primary_undervoltage_threshold);
        aov_hit = (i_aux_overvoltage_threshold != `WSER_VOV_DISABLE)
                  && (i_auxiliary_input_voltage
                      > i_aux_overvoltage_threshold);
        auv_hit = (i_aux_undervoltage_threshold != `WSER_VUV_DISABLE)
                  && (i_auxiliary_input_voltage
                      < i_aux_undervoltage_threshold);
        // A negative limit trips on a more negative power reading
        // [RULE_05] overpower compare
        if (i_overpower_threshold == `WSER_OP_DISABLE) begin
            op_hit = 1'b0;
        end else if (i_overpower_threshold[15]) begin
            op_hit = i_input_power < i_overpower_threshold;
        end else begin
            op_hit = i_input_power > i_overpower_threshold;
        end
    end

    // Flags: the set term wins over a clear in the same cycle
    always_comb begin
        cur_status_next = cur_status_reg;
        in_status_next  = in_status_reg;
        vnd_status_next = vnd_status_reg;
        // [RULE_22] explicit clear
        if (i_clear_faults) begin
            cur_status_next = `WSER_STATUS_RST;
            in_status_next  = `WSER_STATUS_RST;
            vnd_status_next = `WSER_STATUS_RST;
        end
        if (i_sample_valid) begin
            // [RULE_01] overcurrent latch
            if (oc_hit) begin
                cur_status_next[`WSER_BIT_OC] = 1'b1;
            end
            // [RULE_03] primary overvoltage latch
            if (pov_hit) begin
                in_status_next[`WSER_BIT_PRI_OV] = 1'b1;
            end
            // [RULE_04] primary undervoltage latch
            if (puv_hit) begin
                in_status_next[`WSER_BIT_PRI_UV] = 1'b1;
            end
            // [RULE_05] overpower latch
            if (op_hit) begin
                in_status_next[`WSER_BIT_OP] = 1'b1;
            end
            // [RULE_07] aux overvoltage latch
            if (aov_hit) begin
                vnd_status_next[`WSER_BIT_AUX_OV] = 1'b1;
            end
            // [RULE_08] aux undervoltage latch
            if (auv_hit) begin
                vnd_status_next[`WSER_BIT_AUX_UV] = 1'b1;
            end
        end
        // [RULE_20] live summaries
        summary_next = {|cur_status_reg, |in_status_reg, |vnd_status_reg};
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cur_status_reg <= `WSER_STATUS_RST;
            in_status_reg  <= `WSER_STATUS_RST;
            vnd_status_reg <= `WSER_STATUS_RST;
            summary_reg    <= 3'h0;
        end else begin
            cur_status_reg <= cur_status_next;
            in_status_reg  <= in_status_next;
            vnd_status_reg <= vnd_status_next;
            summary_reg    <= summary_next;
        end
    end

    // Energy accumulation; reverse side is outside this block but
    // its samples still count in the shared tally
    always_comb begin
        acc_next   = acc_reg;
        wrap_next  = wrap_reg;
        tally_next = tally_reg;
        // [RULE_18] range differs per variant
        acc_top = SIGNED_VARIANT ? `WSER_ACC_TOP_SIGNED
                                 : `WSER_ACC_TOP_UNSIGNED;
        // Power added in the positive-current case is the reading, or zero if it is negative
        acc_sum  = {1'b0, acc_reg} + {9'h000, i_input_power[15] ? 16'h0000
                                                  : i_input_power};
        acc_wrap = acc_sum > {1'b0, acc_top};
        if (i_sample_valid) begin
            // [RULE_23] tally every sample
            tally_next = tally_reg + 24'h000001;
            // [RULE_11] forward only when current positive
            if (i_sensed_current > 16'sh0000) begin
                if (acc_wrap) begin
                    // [RULE_14] [RULE_15] wrap counting
                    acc_next  = acc_sum[23:0] - acc_top - 24'h000001;
                    wrap_next = wrap_reg + 8'h01;
                end else begin
                    acc_next = acc_sum[23:0];
                end
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            acc_reg   <= 24'h000000;
            wrap_reg  <= 8'h00;
            tally_reg <= 24'h000000;
        end else begin
            acc_reg   <= acc_next;
            wrap_reg  <= wrap_next;
            tally_reg <= tally_next;
        end
    end

    // Read path: the whole answer is taken in one edge, so fields
    // never mix counts from different samples
    always_comb begin
        rd_state_next = rd_state_reg;
        rd_valid_next = 1'b0;
        rd_hit_next   = 1'b0;
        rd_data_next  = rd_data_reg;
        case (rd_state_reg)
            WSER_RD_IDLE: begin
                if (i_rd_strobe) begin
                    rd_valid_next = 1'b1;
                    rd_hit_next   = 1'b1;
                    rd_state_next = WSER_RD_BUSY;
                    case (i_rd_command)
                        // [RULE_02] [RULE_09] reserved zero
                        `WSER_CMD_CUR_STATUS: rd_data_next =
                            {40'h0, cur_status_reg & `WSER_CUR_MASK};
                        // [RULE_06] reserved zero
                        `WSER_CMD_IN_STATUS: rd_data_next =
                            {40'h0, in_status_reg & `WSER_IN_MASK};
                        // [RULE_09] reserved zero
                        `WSER_CMD_VND_STATUS: rd_data_next =
                            {40'h0, vnd_status_reg & `WSER_VND_MASK};
                        // [RULE_10] [RULE_12] [RULE_13] [RULE_16] snapshot
                        // [RULE_17] [RULE_19] top 16 bits, high byte first
                        `WSER_CMD_FWD_ENERGY: rd_data_next =
                            {tally_reg, wrap_reg, acc_reg[23:8]};
                        default: begin
                            rd_data_next = 48'h0;
                            rd_hit_next  = 1'b0;
                        end
                    endcase
                end
            end
            WSER_RD_BUSY: begin
                // One idle cycle between answers
                rd_state_next = WSER_RD_IDLE;
            end
            default: rd_state_next = WSER_RD_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            rd_state_reg <= WSER_RD_IDLE;
            rd_valid_reg <= 1'b0;
            rd_hit_reg   <= 1'b0;
            rd_data_reg  <= 48'h0;
        end else begin
            rd_state_reg <= rd_state_next;
            rd_valid_reg <= rd_valid_next;
            rd_hit_reg   <= rd_hit_next;
            rd_data_reg  <= rd_data_next;
        end
    end

    assign o_rd_valid            = rd_valid_reg;
    assign o_rd_hit              = rd_hit_reg;
    assign o_rd_data             = rd_data_reg;
    assign o_current_summary_bit = summary_reg[2];
    assign o_input_summary_bit   = summary_reg[1];
    assign o_vendor_summary_bit  = summary_reg[0];
endmodule
`default_nettype wire

// ===== hw/wser_cfg.svh
// Offsets, field positions, reset values and disable codes for the block
`ifndef WSER_CFG_SVH
`define WSER_CFG_SVH
`define WSER_CMD_CUR_STATUS   8'h7B
`define WSER_CMD_IN_STATUS    8'h7C
`define WSER_CMD_VND_STATUS   8'h80
`define WSER_CMD_FWD_ENERGY   8'h86
`define WSER_BIT_OC           5
`define WSER_BIT_PRI_OV       6
`define WSER_BIT_PRI_UV       5
`define WSER_BIT_OP           0
`define WSER_BIT_AUX_OV       6
`define WSER_BIT_AUX_UV       5
`define WSER_STATUS_RST       8'h00
`define WSER_CUR_MASK         8'h20
`define WSER_IN_MASK          8'h61
`define WSER_VND_MASK         8'h60
`define WSER_OC_DISABLE       16'h7FFF
`define WSER_VOV_DISABLE      12'hFFF
`define WSER_VUV_DISABLE      12'h000
`define WSER_OP_DISABLE       16'h7FFF
`define WSER_ACC_TOP_UNSIGNED 24'hFFFFFF
`define WSER_ACC_TOP_SIGNED   24'h7FFFFF
`endif

// ===== hw/wser_pkg.sv
// Types shared by the warning status and energy readout block
package wser_pkg;
    typedef enum logic [1:0] {
        WSER_RD_IDLE,
        WSER_RD_BUSY
    } wser_rd_state_t;
    typedef logic [47:0] wser_energy_t;
endpackage

// ===== test/wser_host_model.sv
// Host controller model issuing read and clear commands
`timescale 1ns/100ps
`default_nettype none
module wser_host_model (
    // Clock
    input  wire logic                   i_core_clk,
    // Read answer from the block
    input  wire logic                   i_rd_valid,
    input  wire logic                   i_rd_hit,
    input  wire wser_pkg::wser_energy_t i_rd_data,
    // Commands to the block
    output logic                        o_rd_strobe = 1'b0,
    output logic [7:0]                  o_rd_command = 8'h00,
    output logic                        o_clear_faults = 1'b0
);
    import wser_pkg::*;
    // Released command lines show the inverse so stale codes are not reused
    task automatic rd(input logic [7:0] cmd, output logic vld,
                      output logic hit, output wser_energy_t dat);
        @(posedge i_core_clk);
        o_rd_strobe <= 1'b1;
        o_rd_command <= cmd;
        @(posedge i_core_clk);
        o_rd_strobe <= 1'b0;
        o_rd_command <= ~cmd;
        #1;
        vld = i_rd_valid;
        hit = i_rd_hit;
        dat = i_rd_data;
        @(posedge i_core_clk);
    endtask
    task automatic clear();
        @(posedge i_core_clk);
        o_clear_faults <= 1'b1;
        @(posedge i_core_clk);
        o_clear_faults <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== test/wser_properties.sv
// Port-level assertions for the warning status and energy readout block
`timescale 1ns/100ps
`default_nettype none
`include "wser_cfg.svh"
module wser_checker (
    input wire logic                  i_core_clk,
    input wire logic                  i_reset,
    input wire logic                  i_sample_valid,
    input wire logic signed [15:0]    i_sensed_current,
    input wire logic [11:0]           i_primary_input_voltage,
    input wire logic signed [15:0]    i_overcurrent_threshold,
    input wire logic [11:0]           i_primary_overvoltage_threshold,
    input wire logic                  i_rd_strobe,
    input wire logic [7:0]            i_rd_command,
    input wire logic                  i_clear_faults,
    input wire logic                  o_rd_valid,
    input wire logic                  o_rd_hit,
    input wire wser_pkg::wser_energy_t o_rd_data,
    input wire logic                  o_current_summary_bit,
    input wire logic                  o_input_summary_bit,
    input wire logic                  o_vendor_summary_bit
);
    default clocking dc @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    property p_answer;
        i_rd_strobe && !o_rd_valid |=> o_rd_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_pulse;
        o_rd_valid |=> !o_rd_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long valid");
    property p_hold;
        !o_rd_valid |-> $stable(o_rd_data);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved");
    property p_cur;
        o_rd_valid && $past(i_rd_command) == `WSER_CMD_CUR_STATUS
            |-> (o_rd_data & ~48'h20) == 48'h0;
    endproperty
    a_cur: assert property (p_cur) else $error("cur bits");
    property p_in;
        o_rd_valid && $past(i_rd_command) == `WSER_CMD_IN_STATUS
            |-> (o_rd_data & ~48'h61) == 48'h0;
    endproperty
    a_in: assert property (p_in) else $error("input bits");
    property p_vnd;
        o_rd_valid && $past(i_rd_command) == `WSER_CMD_VND_STATUS
            |-> (o_rd_data & ~48'h60) == 48'h0;
    endproperty
    a_vnd: assert property (p_vnd) else $error("vendor bits");
    property p_oc;
        i_sample_valid && i_sensed_current > i_overcurrent_threshold &&
            i_overcurrent_threshold != 16'h7FFF |-> ##2 o_current_summary_bit;
    endproperty
    a_oc: assert property (p_oc) else $error("oc not set");
    property p_ov;
        i_sample_valid &&
            i_primary_input_voltage > i_primary_overvoltage_threshold &&
            i_primary_overvoltage_threshold != 12'hFFF
            |-> ##2 o_input_summary_bit;
    endproperty
    a_ov: assert property (p_ov) else $error("ov not set");
    property p_latch;
        o_current_summary_bit && !i_clear_faults && !$past(i_clear_faults)
            |=> o_current_summary_bit;
    endproperty
    a_latch: assert property (p_latch) else $error("flag lost");
    property p_clear;
        i_clear_faults && !i_sample_valid |-> ##2 !(o_current_summary_bit ||
            o_input_summary_bit || o_vendor_summary_bit);
    endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    c_energy: cover property (o_rd_valid && o_rd_data[23:16] != 8'h00);
    c_oc: cover property (o_current_summary_bit);
    c_clear: cover property (i_clear_faults ##2 !o_input_summary_bit);
endmodule
`default_nettype wire
bind wser_top wser_checker i_wser_checker (
    .i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_sample_valid(i_sample_valid), .i_sensed_current(i_sensed_current),
    .i_primary_input_voltage(i_primary_input_voltage),
    .i_overcurrent_threshold(i_overcurrent_threshold),
    .i_primary_overvoltage_threshold(i_primary_overvoltage_threshold),
    .i_rd_strobe(i_rd_strobe), .i_rd_command(i_rd_command),
    .i_clear_faults(i_clear_faults), .o_rd_valid(o_rd_valid),
    .o_rd_hit(o_rd_hit), .o_rd_data(o_rd_data),
    .o_current_summary_bit(o_current_summary_bit),
    .o_input_summary_bit(o_input_summary_bit),
    .o_vendor_summary_bit(o_vendor_summary_bit)
);

// ===== test/testbench.sv
// Self-checking bench for the warning status and energy readout block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import wser_pkg::*;
    logic clk = 1'b0, rst = 1'b1, sv = 1'b0, strb, clr, vld, hit;
    logic signed [15:0] cur = 16'h0000, pw = 16'h0000;
    logic signed [15:0] oc_t = 16'h7FFF, op_t = 16'h7FFF;
    logic [11:0] pv = 12'h000, av = 12'h000, pov_t = 12'hFFF;
    logic [11:0] puv_t = 12'h000, aov_t = 12'hFFF, auv_t = 12'h000;
    logic [7:0] cmd;
    logic sc, si, sn;
    wser_energy_t dat;
    int err_total = 0, samples_checked = 0;
    always #4 clk = ~clk;
    wser_top i_wser_top (.i_core_clk(clk), .i_reset(rst),
        .i_sample_valid(sv), .i_sensed_current(cur),
        .i_primary_input_voltage(pv), .i_auxiliary_input_voltage(av),
        .i_input_power(pw), .i_overcurrent_threshold(oc_t),
        .i_primary_overvoltage_threshold(pov_t),
        .i_primary_undervoltage_threshold(puv_t),
        .i_overpower_threshold(op_t), .i_aux_overvoltage_threshold(aov_t),
        .i_aux_undervoltage_threshold(auv_t), .i_rd_strobe(strb),
        .i_rd_command(cmd), .i_clear_faults(clr), .o_rd_valid(vld),
        .o_rd_hit(hit), .o_rd_data(dat), .o_current_summary_bit(sc),
        .o_input_summary_bit(si), .o_vendor_summary_bit(sn));
    wser_host_model i_wser_host_model (.i_core_clk(clk), .i_rd_valid(vld),
        .i_rd_hit(hit), .i_rd_data(dat), .o_rd_strobe(strb),
        .o_rd_command(cmd), .o_clear_faults(clr));
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic h,
                          input wser_energy_t e);
        logic v, g;
        wser_energy_t d;
        i_wser_host_model.rd(c, v, g, d);
        chk({v, g}, {1'b1, h});
        chk(d, e);
    endtask
    task automatic samp(input logic [15:0] c, input logic [11:0] p,
                        input logic [11:0] a, input logic [15:0] w);
        @(posedge clk);
        sv <= 1'b1;
        cur <= c;
        pv <= p;
        av <= a;
        pw <= w;
        @(posedge clk);
        sv <= 1'b0;
    endtask
    task automatic t_reset_values();
        rd_chk(8'h7B, 1'b1, 48'h0);
        rd_chk(8'h7C, 1'b1, 48'h0);
        rd_chk(8'h80, 1'b1, 48'h0);
        rd_chk(8'h86, 1'b1, 48'h0);
        rd_chk(8'h99, 1'b0, 48'h0);
    endtask
    task automatic t_energy();
        logic [31:0] acc;
        acc = 32'h201 * 32'h7FFF;
        samp(16'h0001, 12'hFFF, 12'h000, 16'h7FFF);
        rd_chk(8'h86, 1'b1, {24'h000001, 8'h00, 16'h007F});
        repeat (512) samp(16'h0001, 12'hFFF, 12'h000, 16'h7FFF);
        repeat (3) samp(16'hFFFB, 12'hFFF, 12'h000, 16'h0064);
        rd_chk(8'h86, 1'b1, {24'h000204, acc[31:8]});
        rd_chk(8'h7C, 1'b1, 48'h0);
        rd_chk(8'h7B, 1'b1, 48'h0);
    endtask
    task automatic t_flags();
        @(posedge clk);
        {oc_t, op_t} <= {16'h0064, 16'h00C8};
        {pov_t, puv_t, aov_t, auv_t} <= {12'h800, 12'h100, 12'h800, 12'h100};
        samp(16'h0096, 12'h900, 12'h050, 16'h012C);
        samp(16'h0000, 12'h400, 12'h400, 16'h0000);
        rd_chk(8'h7B, 1'b1, 48'h20);
        rd_chk(8'h7C, 1'b1, 48'h41);
        rd_chk(8'h80, 1'b1, 48'h20);
        chk({sc, si, sn}, 3'h7);
        i_wser_host_model.clear();
        samp(16'h0000, 12'h050, 12'h900, 16'h0000);
        rd_chk(8'h7C, 1'b1, 48'h20);
        rd_chk(8'h80, 1'b1, 48'h40);
        chk({sc, si, sn}, 3'h3);
    endtask
    // Negative power limit, then a reset in mid-run wipes flags and counts
    task automatic t_neg_power_reset();
        i_wser_host_model.clear();
        @(posedge clk);
        op_t <= 16'hFF00;
        samp(16'h0000, 12'h400, 12'h400, 16'hFE00);
        rd_chk(8'h7C, 1'b1, 48'h01);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(8'h7C, 1'b1, 48'h0);
        rd_chk(8'h86, 1'b1, 48'h0);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_energy();
        t_flags();
        t_neg_power_reset();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
